/* File: logic/supply_drop_pkg.sv */
/*
 Shared constants and carrier types for the supply drop monitor control block.
 Assumes a 32-bit classic Wishbone register bus and a 100 MHz system clock.
*/
package supply_drop_pkg;
   // Register byte offsets
   localparam logic [7:0] DETECTOR_CONTROL_OFS = 8'h00;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
   localparam logic [7:0] IRQ_GLOBAL_OFS = 8'h0C;
   // Control register fields and reset value
   localparam int TRIP_LSB = 0;
   localparam int TRIP_W = 4;
   localparam int POWER_BIT = 4;
   localparam int STABLE_BIT = 5;
   localparam logic [7:0] CONTROL_RESET = 8'h05;
   localparam logic [3:0] TRIP_EXTERNAL = 4'hF;
   // Status/mask layout
   localparam int LOW_VOLTAGE_BIT = 0;
   localparam int WAKE_BIT = 1;
   localparam logic [1:0] EVENT_MASK_RESET = 2'h0;
   // Stabilization interval: fixed cycle count, 50 us only while the clock matches CLOCK_MHZ
   localparam int CLOCK_MHZ = 100;
   localparam int SETTLE_US = 50;
   localparam int SETTLE_CYCLES = SETTLE_US * CLOCK_MHZ;
   localparam int SETTLE_W = 16;

   typedef enum logic [1:0] {
      MON_OFF = 2'b00,
      MON_SETTLE = 2'b01,
      MON_READY = 2'b10
   } monitor_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      monitor_state_t state;
      logic [SETTLE_W-1:0] settle_cnt;
      logic [3:0] trip_level_select;
      logic ext_select;
      logic detector_power_enable;
      logic reference_stable;
      logic [1:0] cmp_sync;
      logic [1:0] sleep_sync;
      logic [1:0] status;
      logic [1:0] mask;
      logic global_irq_enable;
      logic irq;
      logic wake;
      logic ack;
      logic [31:0] rdata;
   } monitor_regs_t;
endpackage : supply_drop_pkg

/* File: logic/supply_drop_monitor.sv */
/*
 Control logic of a supply low-voltage detector: control register, settling
 timer, latched low-voltage flag, interrupt and wake request, Wishbone slave.
 Assumes the analog comparator, divider and reference sit outside; the
 comparator output and sleep indication arrive asynchronously.
*/
// Overview of operation
// RULE1 - Comparator low report sets low-voltage flag
// RULE2 - Four-bit field selects one of sixteen taps
// RULE3 - Code all ones routes external trip input
// RULE4 - Bit four powers the detector
// RULE5 - Read-only bit five shows reference stable
// RULE6 - Flag cannot set before reference is stable
// RULE7 - Fixed settle interval after every enable
// RULE8 - Spurious flag clearable by software afterwards
// RULE9 - Flag, enable and global enable raise interrupt
// RULE10 - Detection keeps working during sleep
// RULE11 - Crossing during sleep sets flag, wakes device
// RULE12 - Any reset turns the detector off
// RULE13 - Software follows the documented setup order
// RULE14 - Flag stays latched until software clears
// RULE15 - Asynchronous inputs pass two flip-flops first
`timescale 1ns/1ps
module supply_drop_monitor (
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   // Wishbone slave
   input wire supply_drop_pkg::wb_req_t WB_REQ_IN,
   output supply_drop_pkg::wb_rsp_t WB_RSP_OUT,
   // Analog front end
   input wire logic COMPARATOR_LOW_IN,
   input wire logic SLEEP_ACTIVE_IN,
   output logic DETECTOR_POWER_OUT,
   output logic [3:0] TRIP_LEVEL_OUT,
   output logic EXTERNAL_TRIP_SELECT_OUT,
   // Requests to the processor
   output logic IRQ_OUT,
   output logic WAKE_OUT
);
   import supply_drop_pkg::*;

   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

   monitor_regs_t r;
   monitor_regs_t nxt;
   logic wr;
   logic rd_hit;
   logic low_seen;
   logic [1:0] events;
   logic [1:0] w1c;

   always_comb begin
      nxt = r;
      // Writes land at the edge that shows ack high, where the master samples it
      wr = WB_REQ_IN.cyc && WB_REQ_IN.stb && WB_REQ_IN.we && r.ack;
      w1c = 2'h0;
      // Settling timer restarts on every enable
      case (r.state)
         MON_OFF: begin
            nxt.settle_cnt = '0;
            if (r.detector_power_enable) begin
               nxt.state = MON_SETTLE; // RULE7
            end
         end
         MON_SETTLE: begin
            if (!r.detector_power_enable) begin
               nxt.state = MON_OFF;
            end else if (r.settle_cnt == SETTLE_LAST) begin
               nxt.state = MON_READY; // RULE7
            end else begin
               nxt.settle_cnt = r.settle_cnt + 1'b1;
            end
         end
         MON_READY: begin
            if (!r.detector_power_enable) begin
               nxt.state = MON_OFF;
            end
         end
         default: begin
            nxt.state = MON_OFF;
         end
      endcase
      nxt.reference_stable = (nxt.state == MON_READY); // RULE5
      // Second stage only; first stage never read by logic
      nxt.cmp_sync = {r.cmp_sync[0], COMPARATOR_LOW_IN}; // RULE15
      nxt.sleep_sync = {r.sleep_sync[0], SLEEP_ACTIVE_IN}; // RULE15
      // Gated until stable; comparator already sees selected tap
      low_seen = r.cmp_sync[1] && r.reference_stable && r.detector_power_enable; // RULE1 RULE6
      events[LOW_VOLTAGE_BIT] = low_seen;
      events[WAKE_BIT] = low_seen && r.sleep_sync[1]; // RULE11
      // Bus access
      nxt.ack = WB_REQ_IN.cyc && WB_REQ_IN.stb && !r.ack;
      rd_hit = nxt.ack && !WB_REQ_IN.we;
      if (wr && WB_REQ_IN.sel[0]) begin
         case (WB_REQ_IN.adr)
            DETECTOR_CONTROL_OFS: begin
               nxt.trip_level_select = WB_REQ_IN.dat[TRIP_LSB +: TRIP_W]; // RULE2 RULE3
               nxt.detector_power_enable = WB_REQ_IN.dat[POWER_BIT]; // RULE4
            end
            IRQ_STATUS_OFS: begin
               w1c = WB_REQ_IN.dat[1:0]; // RULE8
            end
            IRQ_MASK_OFS: begin
               nxt.mask = WB_REQ_IN.dat[1:0];
            end
            IRQ_GLOBAL_OFS: begin
               nxt.global_irq_enable = WB_REQ_IN.dat[0];
            end
            default: begin
            end
         endcase
      end
      // Set wins over clear; flag holds until cleared
      nxt.status = (r.status & ~w1c) | events; // RULE14
      // Registered so the routing pin never glitches while the field is rewritten
      nxt.ext_select = (nxt.trip_level_select == TRIP_EXTERNAL); // RULE3
      nxt.rdata = 32'h0;
      if (rd_hit) begin
         case (WB_REQ_IN.adr)
            DETECTOR_CONTROL_OFS: begin
               nxt.rdata[STABLE_BIT] = r.reference_stable; // RULE5
               nxt.rdata[POWER_BIT] = r.detector_power_enable;
               nxt.rdata[TRIP_LSB +: TRIP_W] = r.trip_level_select;
            end
            IRQ_STATUS_OFS: begin
               nxt.rdata[1:0] = r.status;
            end
            IRQ_MASK_OFS: begin
               nxt.rdata[1:0] = r.mask;
            end
            IRQ_GLOBAL_OFS: begin
               nxt.rdata[0] = r.global_irq_enable;
            end
            default: begin
               nxt.rdata = 32'h0;
            end
         endcase
      end
      nxt.irq = r.global_irq_enable && |(nxt.status & nxt.mask); // RULE9
      // Wake ignores the global enable so sleep exits even with interrupts off
      nxt.wake = nxt.status[WAKE_BIT] && nxt.mask[WAKE_BIT]; // RULE11
   end

   // Asynchronous reset puts the detector off with control at reset value
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         r.state <= MON_OFF;
         r.settle_cnt <= '0;
         r.trip_level_select <= CONTROL_RESET[TRIP_LSB +: TRIP_W]; // RULE12
         r.ext_select <= (CONTROL_RESET[TRIP_LSB +: TRIP_W] == TRIP_EXTERNAL); // RULE12
         r.detector_power_enable <= CONTROL_RESET[POWER_BIT]; // RULE12
         r.reference_stable <= 1'b0;
         r.cmp_sync <= 2'h0;
         r.sleep_sync <= 2'h0;
         r.status <= 2'h0;
         r.mask <= EVENT_MASK_RESET;
         r.global_irq_enable <= 1'b0;
         r.irq <= 1'b0;
         r.wake <= 1'b0;
         r.ack <= 1'b0;
         r.rdata <= 32'h0;
      end else begin
         r <= nxt;
      end
   end

   // Front-end outputs are flop-driven; sleep operation relies on the
   // analog comparator holding its level until the clock returns.
   assign DETECTOR_POWER_OUT = r.detector_power_enable; // RULE10
   assign TRIP_LEVEL_OUT = r.trip_level_select; // RULE2
   assign EXTERNAL_TRIP_SELECT_OUT = r.ext_select; // RULE3
   assign IRQ_OUT = r.irq;
   assign WAKE_OUT = r.wake;
   assign WB_RSP_OUT.ack = r.ack;
   assign WB_RSP_OUT.dat = r.rdata;

   // Multi-step behaviours are spelled out as named sequences
   sequence s_enable_rise;
      $rose(r.detector_power_enable);
   endsequence

   sequence s_settle_quiet;
      !r.reference_stable [*8];
   endsequence

   sequence s_bus_taken;
      WB_REQ_IN.cyc && WB_REQ_IN.stb && !r.ack;
   endsequence

   sequence s_ack_once;
      r.ack ##1 !r.ack;
   endsequence

   sequence s_control_write;
      wr && WB_REQ_IN.sel[0] && (WB_REQ_IN.adr == DETECTOR_CONTROL_OFS);
   endsequence

   sequence s_wake_cause;
      r.cmp_sync[1] && r.sleep_sync[1] && r.reference_stable && r.detector_power_enable
      && r.mask[WAKE_BIT] && !wr;
   endsequence

   // Settling and reference
   a_stable_waits_settle: assert property ( // RULE7
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      s_enable_rise |-> s_settle_quiet)
      else $error("Stable flag rose too soon after enable");

   a_stable_full_count: assert property ( // RULE7
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      $rose(r.reference_stable) |-> ($past(r.settle_cnt) == SETTLE_LAST))
      else $error("Stable flag rose before the full settle count");

   a_settle_restart: assert property ( // RULE7
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (r.state == MON_OFF) |=> (r.settle_cnt == '0))
      else $error("Settle count not restarted while off");

   a_disable_unstable: assert property ( // RULE4
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      !r.detector_power_enable |=> ##1 !r.reference_stable)
      else $error("Stable while detector powered down");

   a_stable_read: assert property ( // RULE5
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (rd_hit && (WB_REQ_IN.adr == DETECTOR_CONTROL_OFS))
      |=> (WB_RSP_OUT.dat[STABLE_BIT] == $past(r.reference_stable)))
      else $error("Stable bit read back wrong");

   // Low-voltage flag
   a_no_flag_unstable: assert property ( // RULE6
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (!r.reference_stable && !r.status[LOW_VOLTAGE_BIT]) |=> !r.status[LOW_VOLTAGE_BIT])
      else $error("Low-voltage flag set before reference stable");

   a_flag_sets_low: assert property ( // RULE1
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (r.cmp_sync[1] && r.reference_stable && r.detector_power_enable)
      |=> r.status[LOW_VOLTAGE_BIT])
      else $error("Low report did not set the flag");

   a_flag_latched: assert property ( // RULE14
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (r.status[LOW_VOLTAGE_BIT] && !w1c[LOW_VOLTAGE_BIT]) |=> r.status[LOW_VOLTAGE_BIT])
      else $error("Flag dropped without software clear");

   a_flag_clears: assert property ( // RULE8
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (w1c[LOW_VOLTAGE_BIT] && !events[LOW_VOLTAGE_BIT]) |=> !r.status[LOW_VOLTAGE_BIT])
      else $error("Software clear of the flag ignored");

   a_sync_two_stage: assert property ( // RULE15
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (r.cmp_sync[1] == $past(COMPARATOR_LOW_IN, 2)) || !$past(RESET_N_IN, 1)
      || !$past(RESET_N_IN, 2))
      else $error("Comparator sync depth wrong");

   // Interrupt and wake requests
   a_irq_follows: assert property ( // RULE9
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      (r.status[LOW_VOLTAGE_BIT] && r.mask[LOW_VOLTAGE_BIT] && r.global_irq_enable && !wr)
      |=> IRQ_OUT)
      else $error("Interrupt missing for enabled flag");

   a_irq_gated: assert property ( // RULE9
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      IRQ_OUT |-> $past(r.global_irq_enable))
      else $error("Interrupt without global enable");

   a_irq_needs_flag: assert property ( // RULE9
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      IRQ_OUT |-> (|(r.status & r.mask)))
      else $error("Interrupt without an unmasked flag");

   a_sleep_wakes: assert property ( // RULE11
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      s_wake_cause |=> WAKE_OUT)
      else $error("No wake on low supply in sleep");

   a_wake_needs_flag: assert property ( // RULE11
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      WAKE_OUT |-> (r.status[WAKE_BIT] && r.mask[WAKE_BIT]))
      else $error("Wake without an unmasked wake flag");

   a_wake_in_sleep: assert property ( // RULE10
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      $rose(r.status[WAKE_BIT]) |-> $past(r.sleep_sync[1]))
      else $error("Wake flag set outside sleep");

   // Control register and front end
   a_power_follows: assert property ( // RULE4
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      s_control_write |=> (DETECTOR_POWER_OUT == $past(WB_REQ_IN.dat[POWER_BIT])))
      else $error("Power enable did not follow the write");

   a_trip_follows: assert property ( // RULE2
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      s_control_write |=> (TRIP_LEVEL_OUT == $past(WB_REQ_IN.dat[TRIP_LSB +: TRIP_W])))
      else $error("Trip level did not follow the write");

   a_ext_select: assert property ( // RULE3
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      EXTERNAL_TRIP_SELECT_OUT == (TRIP_LEVEL_OUT == TRIP_EXTERNAL))
      else $error("External trip select mismatch");

   a_reset_off: assert property ( // RULE12
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      $rose(RESET_N_IN)
      |-> (!DETECTOR_POWER_OUT && (TRIP_LEVEL_OUT == CONTROL_RESET[TRIP_LSB +: TRIP_W])))
      else $error("Control not at reset value after reset");

   // Register bus handshake
   a_ack_pulse: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      s_bus_taken |=> s_ack_once)
      else $error("Bus acknowledge not a single pulse");

   a_rdata_idle: assert property (
      @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
      !r.ack |-> (WB_RSP_OUT.dat == 32'h0))
      else $error("Read data shown without acknowledge");
endmodule : supply_drop_monitor

/* File: tb/supply_drop_monitor_tb.sv */
/*
 Self-checking bench for the supply drop monitor control block.
 Assumes the package constants and a one-cycle Wishbone answer; drives the
 comparator and sleep levels directly in place of the analog front end.
*/
`timescale 1ns/1ps
module supply_drop_monitor_tb;
   import supply_drop_pkg::*;
   logic clock;
   logic reset_n;
   wb_req_t req;
   wb_rsp_t rsp;
   logic comparator_low;
   logic sleep_active;
   logic power;
   logic ext_sel;
   logic irq;
   logic wake;
   logic [3:0] trip;
   logic [31:0] rd;
   int fails;
   int comparisons;
   int n;

   supply_drop_monitor dut (
      .CLOCK_IN(clock),
      .RESET_N_IN(reset_n),
      .WB_REQ_IN(req),
      .WB_RSP_OUT(rsp),
      .COMPARATOR_LOW_IN(comparator_low),
      .SLEEP_ACTIVE_IN(sleep_active),
      .DETECTOR_POWER_OUT(power),
      .TRIP_LEVEL_OUT(trip),
      .EXTERNAL_TRIP_SELECT_OUT(ext_sel),
      .IRQ_OUT(irq),
      .WAKE_OUT(wake)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic end_sim;
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One classic cycle; the request is held until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge clock);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
      @(posedge clock);
      // Only the watchdog ends a wait that never sees ack
      while (rsp.ack !== 1'b1) begin
         @(posedge clock);
      end
      rd = rsp.dat;
      req <= '0;
   endtask : bus

   task automatic expect_rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
      bus(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask : expect_rd

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_sim();
   end

   initial begin
      req = '0;
      comparator_low = 1'b0;
      sleep_active = 1'b0;
      reset_n = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      check("power_rst", 32'(power), 32'h0);
      expect_rd(DETECTOR_CONTROL_OFS, 32'(CONTROL_RESET), "control_rst");
      expect_rd(8'h10, 32'h0, "unmapped");
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, DETECTOR_CONTROL_OFS, 32'(c));
         @(posedge clock);
         check("trip_out", 32'(trip), 32'(c));
         check("ext_sel", 32'(ext_sel), 32'(c == 15));
         expect_rd(DETECTOR_CONTROL_OFS, 32'(c), "trip_rd");
      end
      // Comparator already low while settling: the flag must stay blocked
      comparator_low <= 1'b1;
      bus(1'b1, DETECTOR_CONTROL_OFS, 32'h1E);
      @(posedge clock);
      check("power_on", 32'(power), 32'h1);
      repeat (SETTLE_CYCLES - 20) @(posedge clock);
      expect_rd(DETECTOR_CONTROL_OFS, 32'h1E, "not_stable");
      expect_rd(IRQ_STATUS_OFS, 32'h0, "flag_blocked");
      n = 0;
      do begin
         bus(1'b0, DETECTOR_CONTROL_OFS, 32'h0);
         n++;
      end while (rd[STABLE_BIT] !== 1'b1 && n < 30);
      check("stable", rd, 32'h3E);
      repeat (8) @(posedge clock);
      expect_rd(IRQ_STATUS_OFS, 32'h1, "flag_set");
      comparator_low <= 1'b0;
      repeat (8) @(posedge clock);
      expect_rd(IRQ_STATUS_OFS, 32'h1, "flag_latched");
      bus(1'b1, IRQ_STATUS_OFS, 32'h1);
      expect_rd(IRQ_STATUS_OFS, 32'h0, "flag_clear");
      comparator_low <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         for (int g = 0; g < 2; g++) begin
            bus(1'b1, IRQ_MASK_OFS, 32'(m));
            bus(1'b1, IRQ_GLOBAL_OFS, 32'(g));
            repeat (8) @(posedge clock);
            check("irq", 32'(irq), 32'(m & g));
         end
      end
      comparator_low <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1'b1, IRQ_STATUS_OFS, 32'h1);
      bus(1'b1, IRQ_MASK_OFS, 32'h2);
      bus(1'b1, IRQ_GLOBAL_OFS, 32'h0);
      sleep_active <= 1'b1;
      repeat (4) @(posedge clock);
      comparator_low <= 1'b1;
      repeat (8) @(posedge clock);
      check("wake", 32'(wake), 32'h1);
      check("irq_sleep", 32'(irq), 32'h0);
      expect_rd(IRQ_STATUS_OFS, 32'h3, "sleep_flags");
      comparator_low <= 1'b0;
      sleep_active <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1'b1, IRQ_STATUS_OFS, 32'h3);
      repeat (4) @(posedge clock);
      check("wake_clear", 32'(wake), 32'h0);
      // Reset in mid-run must switch the detector off again
      reset_n <= 1'b0;
      @(posedge clock);
      check("power_rst2", 32'(power), 32'h0);
      reset_n <= 1'b1;
      expect_rd(DETECTOR_CONTROL_OFS, 32'(CONTROL_RESET), "control_rst2");
      end_sim();
   end
endmodule : supply_drop_monitor_tb
